// >>> rtl/hub_port_end.sv
`timescale 1ns/100ps
// gray-pointer crossing buffer, link side writes, core side reads
module hub_sync_fifo #(
    parameter int W     = graphics_port_pkg::WORD_W,
    parameter int DEPTH = graphics_port_pkg::FIFO_DEPTH
) (
    input  wire logic         wr_clk,
    input  wire logic         wr_rst_n,
    input  wire logic         wr_valid,
    input  wire logic [W-1:0] wr_data,
    input  wire logic         rd_clk,
    input  wire logic         rd_rst_n,
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [W-1:0]      rd_data
);
    localparam int AW = $clog2(DEPTH);

    // refuse depths the pointer logic cannot serve
    generate
        if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("fifo depth must be a power of two, four or more");
        end
    endgenerate

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    logic [W-1:0] mem [DEPTH];       // entries, written on the link clock
    logic [AW:0]  wr_bin_r;          // write pointer, binary
    logic [AW:0]  wr_bin_nxt;
    logic [AW:0]  wr_gray_r;         // write pointer, published
    logic [AW:0]  rd_gray_w1_r;      // read pointer sync, first stage
    logic [AW:0]  rd_gray_w2_r;      // read pointer sync, second stage
    logic [AW:0]  rd_bin_r;          // read pointer, binary
    logic [AW:0]  rd_bin_nxt;
    logic [AW:0]  rd_gray_r;         // read pointer, published
    logic [AW:0]  wr_gray_r1_r;      // write pointer sync, first stage
    logic [AW:0]  wr_gray_r2_r;      // write pointer sync, second stage
    logic         wr_full;
    logic         wr_take;
    logic         rd_take;

    // full when the pointers differ only in the top two gray bits
    assign wr_full    = wr_gray_r == {~rd_gray_w2_r[AW:AW-1], rd_gray_w2_r[AW-2:0]};
    assign wr_take    = wr_valid && !wr_full;     // a beat on full is dropped
    assign wr_bin_nxt = wr_bin_r + 1'b1;
    assign rd_valid   = rd_gray_r != wr_gray_r2_r;
    assign rd_take    = rd_valid && rd_ready;
    assign rd_bin_nxt = rd_bin_r + 1'b1;
    assign rd_data    = mem[rd_bin_r[AW-1:0]];

    // entry store
    always_ff @(posedge wr_clk) begin
        if (wr_take) begin
            mem[wr_bin_r[AW-1:0]] <= wr_data;
        end
    end

    // write pointer
    always_ff @(posedge wr_clk) begin
        if (!wr_rst_n) begin
            wr_bin_r  <= '0;
            wr_gray_r <= '0;
        end else if (wr_take) begin
            wr_bin_r  <= wr_bin_nxt;
            wr_gray_r <= to_gray(wr_bin_nxt);
        end
    end

    // read pointer into the write domain
    always_ff @(posedge wr_clk) begin
        rd_gray_w1_r <= rd_gray_r;
        rd_gray_w2_r <= rd_gray_w1_r;
    end

    // read pointer
    always_ff @(posedge rd_clk) begin
        if (!rd_rst_n) begin
            rd_bin_r  <= '0;
            rd_gray_r <= '0;
        end else if (rd_take) begin
            rd_bin_r  <= rd_bin_nxt;
            rd_gray_r <= to_gray(rd_bin_nxt);
        end
    end

    // write pointer into the read domain
    always_ff @(posedge rd_clk) begin
        wr_gray_r1_r <= wr_gray_r;
        wr_gray_r2_r <= wr_gray_r1_r;
    end
endmodule : hub_sync_fifo

// Notes on behaviour
// - double rate: low strobe times low half
// - data source drives strobes, receiver samples
// - double rate: complement strobes are ignored
// - quad rate: low strobe pair is differential
// - double rate: high strobe times high half
// - quad rate: high strobe pair is differential
// - master drives sideband strobe for requests
// - quad rate sideband pair, hub never drives
// - sideband and data paths run independently
module hub_port_end (
    input  wire logic                             clk_sys,
    input  wire logic                             reset_n,
    graphics_port_if.hub                          link,
    input  wire logic                             quad_rate_mode,
    input  wire logic                             tx_valid,
    input  wire logic [graphics_port_pkg::WORD_W-1:0] tx_word,
    output logic                                  tx_ready,
    output logic                                  ad_rx_valid,
    input  wire logic                             ad_rx_ready,
    output logic [graphics_port_pkg::WORD_W-1:0]  ad_rx_word,
    output logic                                  sb_rx_valid,
    input  wire logic                             sb_rx_ready,
    output logic [graphics_port_pkg::SB_W-1:0]    sb_rx_addr
);
    localparam int CAP_W = graphics_port_pkg::CAP_W;
    localparam int BEL   = graphics_port_pkg::BE_LSB;

    logic                                  link_rst_s1_r; // reset sync, first stage
    logic                                  link_rst_n_r;  // reset in link domain
    logic                                  quad_s1_r;     // mode sync, first stage
    logic                                  quad_r;        // mode in link domain
    logic [graphics_port_pkg::LANE_W-1:0]  lane_in [2];   // resolved halves
    logic [1:0]                            beat;          // valid beat per half
    logic [1:0]                            got_r;         // half already held
    logic [CAP_W-1:0]                      half_r [2];    // held halves
    logic [CAP_W-1:0]                      half_now [2];  // this beat or held
    logic                                  ad_push;
    logic [graphics_port_pkg::WORD_W-1:0]  ad_word;
    logic                                  sb_beat;
    logic                                  tx_req_r;      // core side request toggle
    logic [graphics_port_pkg::WORD_W-1:0]  tx_word_r;     // word held for the link
    logic                                  ack_s1_r;      // ack sync, first stage
    logic                                  ack_s2_r;      // ack sync, second stage
    logic                                  req_s1_r;      // req sync, first stage
    logic                                  req_s2_r;      // req sync, second stage
    logic                                  req_seen_r;    // last request served
    logic                                  drive_r;       // hub owns the halves
    logic [graphics_port_pkg::LANE_W-1:0]  low_o_r;
    logic [graphics_port_pkg::LANE_W-1:0]  high_o_r;

    // reset and mode brought onto the link clock
    always_ff @(posedge link.link_clk) begin
        link_rst_s1_r <= reset_n;
        link_rst_n_r  <= link_rst_s1_r;
        quad_s1_r     <= quad_rate_mode;
        quad_r        <= quad_s1_r;
    end

    assign lane_in[0] = link.low_lane;
    assign lane_in[1] = link.high_lane;

    // per-half capture, each half on its own strobe
    generate
        for (genvar h = 0; h < 2; h++) begin : g_half
            // true strobe low marks a beat; complement checked only in quad rate
            assign beat[h] = !drive_r
                && lane_in[h][graphics_port_pkg::STB_BIT] == graphics_port_pkg::STROBE_BEAT
                && (!quad_r || lane_in[h][graphics_port_pkg::STBN_BIT]);
            assign half_now[h] = beat[h] ? lane_in[h][CAP_W-1:0] : half_r[h];

            // hold a half until its partner arrives
            always_ff @(posedge link.link_clk) begin
                if (!link_rst_n_r) begin
                    got_r[h]  <= 1'b0;
                    half_r[h] <= '0;
                end else begin
                    if (ad_push) begin
                        got_r[h] <= 1'b0;
                    end else if (beat[h]) begin
                        got_r[h] <= 1'b1;
                    end
                    if (beat[h]) begin
                        half_r[h] <= lane_in[h][CAP_W-1:0];
                    end
                end
            end
        end
    endgenerate

    // low half fills the low bits, high half the high bits
    assign ad_push = &(got_r | beat);
    assign ad_word = {half_now[1][BEL +: 2], half_now[0][BEL +: 2],
                      half_now[1][15:0], half_now[0][15:0]};

    // sideband beat, hub only receives the strobe pair
    assign sb_beat = link.sideband_request_strobe == graphics_port_pkg::STROBE_BEAT
                     && (!quad_r || link.sideband_request_strobe_n);

    // data path into the core clock
    hub_sync_fifo #(
        .W     (graphics_port_pkg::WORD_W),
        .DEPTH (graphics_port_pkg::FIFO_DEPTH)
    ) u_ad_fifo (
        .wr_clk   (link.link_clk),
        .wr_rst_n (link_rst_n_r),
        .wr_valid (ad_push),
        .wr_data  (ad_word),
        .rd_clk   (clk_sys),
        .rd_rst_n (reset_n),
        .rd_valid (ad_rx_valid),
        .rd_ready (ad_rx_ready),
        .rd_data  (ad_rx_word)
    );

    // sideband path, separate from the data path
    hub_sync_fifo #(
        .W     (graphics_port_pkg::SB_W),
        .DEPTH (graphics_port_pkg::FIFO_DEPTH)
    ) u_sb_fifo (
        .wr_clk   (link.link_clk),
        .wr_rst_n (link_rst_n_r),
        .wr_valid (sb_beat),
        .wr_data  (link.sideband_addr),
        .rd_clk   (clk_sys),
        .rd_rst_n (reset_n),
        .rd_valid (sb_rx_valid),
        .rd_ready (sb_rx_ready),
        .rd_data  (sb_rx_addr)
    );

    // core side of the transmit handshake
    assign tx_ready = ack_s2_r == tx_req_r;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            tx_req_r  <= 1'b0;
            tx_word_r <= '0;
        end else if (tx_valid && tx_ready) begin
            tx_req_r  <= ~tx_req_r;
            tx_word_r <= tx_word;
        end
    end

    // ack back into the core clock
    always_ff @(posedge clk_sys) begin
        ack_s1_r <= req_seen_r;
        ack_s2_r <= ack_s1_r;
    end

    // request into the link clock
    always_ff @(posedge link.link_clk) begin
        req_s1_r <= tx_req_r;
        req_s2_r <= req_s1_r;
    end

    // one beat on both halves per request, released otherwise
    always_ff @(posedge link.link_clk) begin
        if (!link_rst_n_r) begin
            req_seen_r <= 1'b0;
            drive_r    <= 1'b0;
            low_o_r    <= graphics_port_pkg::LANE_RELEASED;
            high_o_r   <= graphics_port_pkg::LANE_RELEASED;
        end else if (req_s2_r != req_seen_r) begin
            req_seen_r <= req_s2_r;
            drive_r    <= 1'b1;
            low_o_r    <= {~graphics_port_pkg::STROBE_BEAT, graphics_port_pkg::STROBE_BEAT,
                           tx_word_r[32 +: 2], tx_word_r[15:0]};
            high_o_r   <= {~graphics_port_pkg::STROBE_BEAT, graphics_port_pkg::STROBE_BEAT,
                           tx_word_r[34 +: 2], tx_word_r[31:16]};
        end else begin
            drive_r    <= 1'b0;
            low_o_r    <= graphics_port_pkg::LANE_RELEASED;
            high_o_r   <= graphics_port_pkg::LANE_RELEASED;
        end
    end

    assign link.hub_low_o     = low_o_r;
    assign link.hub_high_o    = high_o_r;
    assign link.hub_low_oe_n  = ~drive_r;
    assign link.hub_high_oe_n = ~drive_r;
endmodule : hub_port_end

// >>> rtl/graphics_port_pkg.sv
package graphics_port_pkg;
    // lane layout: one half of the port as driven by either end
    localparam int HALF_W     = 16;                 // address/data bits per half
    localparam int BE_HALF_W  = 2;                  // byte enables per half
    localparam int AD_LSB     = 0;                  // address/data field
    localparam int BE_LSB     = 16;                 // byte enable field
    localparam int STB_BIT    = 18;                 // true strobe
    localparam int STBN_BIT   = 19;                 // complement strobe
    localparam int LANE_W     = 20;                 // whole lane
    localparam int CAP_W      = HALF_W + BE_HALF_W; // captured part of a lane
    // word layout on the user side: be_n in the top nibble
    localparam int WORD_W     = 36;
    localparam int WORD_BE_LSB = 32;
    localparam int SB_W       = 8;                  // sideband request bus
    localparam int FIFO_DEPTH = 4;                  // crossing buffer entries
    // strobe levels: a low true strobe marks a valid beat
    localparam logic STROBE_REST = 1'h1;
    localparam logic STROBE_BEAT = 1'h0;
    localparam logic [LANE_W-1:0] LANE_RELEASED = 20'hF_FFFF;
    localparam logic [SB_W-1:0]   SB_IDLE       = 8'hFF;
endpackage : graphics_port_pkg

// >>> rtl/graphics_port_if.sv
`timescale 1ns/100ps
interface graphics_port_if (
    input wire logic link_clk
);
    // per-end drivers, oe_n low while that end drives the half
    logic [graphics_port_pkg::LANE_W-1:0] hub_low_o;
    logic [graphics_port_pkg::LANE_W-1:0] hub_high_o;
    logic [graphics_port_pkg::LANE_W-1:0] mst_low_o;
    logic [graphics_port_pkg::LANE_W-1:0] mst_high_o;
    logic                                 hub_low_oe_n;
    logic                                 hub_high_oe_n;
    logic                                 mst_low_oe_n;
    logic                                 mst_high_oe_n;
    // resolved wires, pulled high when nobody drives
    logic [graphics_port_pkg::LANE_W-1:0] low_lane;
    logic [graphics_port_pkg::LANE_W-1:0] high_lane;
    logic [graphics_port_pkg::HALF_W-1:0] port_addr_data_low;
    logic [graphics_port_pkg::HALF_W-1:0] port_addr_data_high;
    logic [1:0]                           port_byte_enable_low_n;
    logic [1:0]                           port_byte_enable_high_n;
    logic                                 low_half_data_strobe;
    logic                                 low_half_data_strobe_n;
    logic                                 high_half_data_strobe;
    logic                                 high_half_data_strobe_n;
    // sideband, driven by the master only
    logic [graphics_port_pkg::SB_W-1:0]   sideband_addr;
    logic                                 sideband_request_strobe;
    logic                                 sideband_request_strobe_n;

    // wire resolution
    assign low_lane  = !hub_low_oe_n  ? hub_low_o  :
                       !mst_low_oe_n  ? mst_low_o  : graphics_port_pkg::LANE_RELEASED;
    assign high_lane = !hub_high_oe_n ? hub_high_o :
                       !mst_high_oe_n ? mst_high_o : graphics_port_pkg::LANE_RELEASED;
    assign port_addr_data_low      = low_lane[15:0];
    assign port_addr_data_high     = high_lane[15:0];
    assign port_byte_enable_low_n  = low_lane[17:16];
    assign port_byte_enable_high_n = high_lane[17:16];
    assign low_half_data_strobe    = low_lane[graphics_port_pkg::STB_BIT];
    assign low_half_data_strobe_n  = low_lane[graphics_port_pkg::STBN_BIT];
    assign high_half_data_strobe   = high_lane[graphics_port_pkg::STB_BIT];
    assign high_half_data_strobe_n = high_lane[graphics_port_pkg::STBN_BIT];

    modport hub (
        input  link_clk, low_lane, high_lane, sideband_addr,
        input  sideband_request_strobe, sideband_request_strobe_n,
        output hub_low_o, hub_high_o, hub_low_oe_n, hub_high_oe_n
    );
    modport master (
        input  link_clk, low_lane, high_lane,
        output mst_low_o, mst_high_o, mst_low_oe_n, mst_high_oe_n,
        output sideband_addr, sideband_request_strobe, sideband_request_strobe_n
    );
endinterface : graphics_port_if

// >>> rtl/master_port_end.sv
`timescale 1ns/100ps
// graphics master end, all logic on the link clock
module master_port_end (
    graphics_port_if.master                          link,
    input  wire logic                                reset_n,
    input  wire logic                                quad_rate_mode,
    input  wire logic                                ad_tx_valid,
    input  wire logic [graphics_port_pkg::WORD_W-1:0] ad_tx_word,
    input  wire logic                                sb_tx_valid,
    input  wire logic [graphics_port_pkg::SB_W-1:0]  sb_tx_addr,
    output logic                                     ad_rx_valid,
    output logic [graphics_port_pkg::WORD_W-1:0]     ad_rx_word
);
    localparam int CAP_W = graphics_port_pkg::CAP_W;
    localparam int BEL   = graphics_port_pkg::BE_LSB;

    logic [graphics_port_pkg::LANE_W-1:0] lane_in [2];   // resolved halves
    logic [1:0]                           beat;          // hub beat per half
    logic [1:0]                           got_r;         // half already held
    logic [CAP_W-1:0]                     half_r [2];
    logic [CAP_W-1:0]                     half_now [2];
    logic                                 ad_push;
    logic                                 drive_r;       // master owns the halves
    logic [graphics_port_pkg::LANE_W-1:0] low_o_r;
    logic [graphics_port_pkg::LANE_W-1:0] high_o_r;
    logic                                 sb_stb_r;      // sideband true strobe
    logic [graphics_port_pkg::SB_W-1:0]   sb_addr_r;
    logic                                 stbn_rest;     // complement level at rest
    logic                                 rst_s1_r;      // reset sync, first stage
    logic                                 rst_n_r;       // reset on the link clock
    logic                                 quad_s1_r;     // mode sync, first stage
    logic                                 quad_r;        // mode on the link clock

    // reset and mode come from another clock, two flops before use
    always_ff @(posedge link.link_clk) begin
        rst_s1_r  <= reset_n;
        rst_n_r   <= rst_s1_r;
        quad_s1_r <= quad_rate_mode;
        quad_r    <= quad_s1_r;
    end

    assign lane_in[0] = link.low_lane;
    assign lane_in[1] = link.high_lane;

    // complement mirrors the strobe in quad rate, idles high in double rate
    assign stbn_rest = quad_r ? ~graphics_port_pkg::STROBE_REST
                                      : graphics_port_pkg::STROBE_REST;

    // receive each half on its own strobe
    generate
        for (genvar h = 0; h < 2; h++) begin : g_half
            assign beat[h] = !drive_r
                && lane_in[h][graphics_port_pkg::STB_BIT] == graphics_port_pkg::STROBE_BEAT
                && (!quad_r || lane_in[h][graphics_port_pkg::STBN_BIT]);
            assign half_now[h] = beat[h] ? lane_in[h][CAP_W-1:0] : half_r[h];

            // hold a half until its partner arrives
            always_ff @(posedge link.link_clk) begin
                if (!rst_n_r) begin
                    got_r[h]  <= 1'b0;
                    half_r[h] <= '0;
                end else begin
                    if (ad_push) begin
                        got_r[h] <= 1'b0;
                    end else if (beat[h]) begin
                        got_r[h] <= 1'b1;
                    end
                    if (beat[h]) begin
                        half_r[h] <= lane_in[h][CAP_W-1:0];
                    end
                end
            end
        end
    endgenerate

    assign ad_push = &(got_r | beat);

    // received word, registered
    always_ff @(posedge link.link_clk) begin
        if (!rst_n_r) begin
            ad_rx_valid <= 1'b0;
            ad_rx_word  <= '0;
        end else begin
            ad_rx_valid <= ad_push;
            if (ad_push) begin
                ad_rx_word <= {half_now[1][BEL +: 2], half_now[0][BEL +: 2],
                               half_now[1][15:0], half_now[0][15:0]};
            end
        end
    end

    // data beat: both halves with their own strobe pairs
    always_ff @(posedge link.link_clk) begin
        if (!rst_n_r) begin
            drive_r  <= 1'b0;
            low_o_r  <= graphics_port_pkg::LANE_RELEASED;
            high_o_r <= graphics_port_pkg::LANE_RELEASED;
        end else if (ad_tx_valid) begin
            drive_r  <= 1'b1;
            low_o_r  <= {~graphics_port_pkg::STROBE_BEAT, graphics_port_pkg::STROBE_BEAT,
                         ad_tx_word[32 +: 2], ad_tx_word[15:0]};
            high_o_r <= {~graphics_port_pkg::STROBE_BEAT, graphics_port_pkg::STROBE_BEAT,
                         ad_tx_word[34 +: 2], ad_tx_word[31:16]};
        end else begin
            drive_r  <= 1'b0;
            low_o_r  <= graphics_port_pkg::LANE_RELEASED;
            high_o_r <= graphics_port_pkg::LANE_RELEASED;
        end
    end

    assign link.mst_low_o     = low_o_r;
    assign link.mst_high_o    = high_o_r;
    assign link.mst_low_oe_n  = ~drive_r;
    assign link.mst_high_oe_n = ~drive_r;

    // sideband request beat, independent of the data halves
    always_ff @(posedge link.link_clk) begin
        if (!rst_n_r) begin
            sb_stb_r  <= graphics_port_pkg::STROBE_REST;
            sb_addr_r <= graphics_port_pkg::SB_IDLE;
        end else if (sb_tx_valid) begin
            sb_stb_r  <= graphics_port_pkg::STROBE_BEAT;
            sb_addr_r <= sb_tx_addr;
        end else begin
            sb_stb_r  <= graphics_port_pkg::STROBE_REST;
            sb_addr_r <= graphics_port_pkg::SB_IDLE;
        end
    end

    assign link.sideband_addr             = sb_addr_r;
    assign link.sideband_request_strobe   = sb_stb_r;
    // beat: complement high; rest: follows mode
    assign link.sideband_request_strobe_n = sb_stb_r ? stbn_rest
                                                     : ~graphics_port_pkg::STROBE_BEAT;
endmodule : master_port_end

// >>> tb/graphics_port_strobe_timing_monitor.sv
`timescale 1ns/100ps
// strobe and release checks on the link clock
module graphics_port_strobe_timing_monitor (
    input wire logic        link_clk,
    input wire logic        reset_n,
    input wire logic        quad_rate_mode,
    input wire logic        hub_low_oe_n,
    input wire logic        hub_high_oe_n,
    input wire logic        mst_low_oe_n,
    input wire logic        mst_high_oe_n,
    input wire logic [19:0] low_lane,
    input wire logic [19:0] high_lane,
    input wire logic [7:0]  sideband_addr,
    input wire logic        sideband_request_strobe,
    input wire logic        sideband_request_strobe_n
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!reset_n);
    // hub drives both halves in the same cycle
    property p_hub_pair; hub_low_oe_n == hub_high_oe_n; endproperty
    a_hub_pair: assert property (p_hub_pair)
        else $error("hub halves driven apart");
    // hub drive lasts one link cycle, then released
    property p_hub_one; !hub_low_oe_n |=> hub_low_oe_n; endproperty
    a_hub_one: assert property (p_hub_one)
        else $error("hub drive held too long");
    // hub beat: true strobe low, complement high
    property p_hub_stb; !hub_low_oe_n |-> low_lane[19:18] == 2'h2 && high_lane[19:18] == 2'h2;
    endproperty
    a_hub_stb: assert property (p_hub_stb)
        else $error("hub strobe pair wrong");
    // master beat on low half
    property p_mst_low; !mst_low_oe_n && hub_low_oe_n |-> low_lane[19:18] == 2'h2; endproperty
    a_mst_low: assert property (p_mst_low)
        else $error("master low strobe wrong");
    // master beat on high half
    property p_mst_high; !mst_high_oe_n && hub_high_oe_n |-> high_lane[19:18] == 2'h2;
    endproperty
    a_mst_high: assert property (p_mst_high)
        else $error("master high strobe wrong");
    // never two drivers on the low half
    property p_one_drv; hub_low_oe_n || mst_low_oe_n; endproperty
    a_one_drv: assert property (p_one_drv)
        else $error("both ends drive low half");
    // sideband beat carries complement high
    property p_sb_pair; !sideband_request_strobe |-> sideband_request_strobe_n; endproperty
    a_sb_pair: assert property (p_sb_pair)
        else $error("sideband strobe pair wrong");
    // sideband rest levels follow the rate, once the mode has passed the master's sync
    property p_sb_rest; sideband_request_strobe && $stable(quad_rate_mode)
        && quad_rate_mode == $past(quad_rate_mode, 2)
        |-> sideband_request_strobe_n != quad_rate_mode && sideband_addr == 8'hFF; endproperty
    a_sb_rest: assert property (p_sb_rest)
        else $error("sideband rest level wrong");
endmodule : graphics_port_strobe_timing_monitor

// >>> tb/graphics_port_strobe_timing_tb_top.sv
`timescale 1ns/100ps
// hub and master face to face, bench drives both user sides
module graphics_port_strobe_timing_tb_top;
    logic clk_sys = 0, link_clk = 0, reset_n = 0, quad = 0, tx_valid = 0, tx_ready;
    logic h_v, h_rdy = 0, s_v, s_rdy = 0, m_tv = 0, m_sv = 0, m_rv;
    logic [35:0] tx_word = 0, h_w, m_tw = 0, m_rw;
    logic [7:0] m_sa = 0, s_a;
    int fails = 0, total_checks = 0, cyc = 0;
    always #20 clk_sys = ~clk_sys;
    always #24 link_clk = ~link_clk;
    graphics_port_if pif (.link_clk(link_clk));
    hub_port_end hub_port_end_i (.clk_sys(clk_sys), .reset_n(reset_n), .link(pif),
        .quad_rate_mode(quad), .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
        .ad_rx_valid(h_v), .ad_rx_ready(h_rdy), .ad_rx_word(h_w), .sb_rx_valid(s_v),
        .sb_rx_ready(s_rdy), .sb_rx_addr(s_a));
    master_port_end master_port_end_i (.link(pif), .reset_n(reset_n), .quad_rate_mode(quad),
        .ad_tx_valid(m_tv), .ad_tx_word(m_tw), .sb_tx_valid(m_sv), .sb_tx_addr(m_sa),
        .ad_rx_valid(m_rv), .ad_rx_word(m_rw));
    graphics_port_strobe_timing_monitor graphics_port_strobe_timing_monitor_i (
        .link_clk(link_clk), .reset_n(reset_n), .quad_rate_mode(quad),
        .hub_low_oe_n(pif.hub_low_oe_n), .hub_high_oe_n(pif.hub_high_oe_n),
        .mst_low_oe_n(pif.mst_low_oe_n), .mst_high_oe_n(pif.mst_high_oe_n),
        .low_lane(pif.low_lane), .high_lane(pif.high_lane), .sideband_addr(pif.sideband_addr),
        .sideband_request_strobe(pif.sideband_request_strobe),
        .sideband_request_strobe_n(pif.sideband_request_strobe_n));
    // compare and count
    task automatic check(string n, logic [35:0] seen, logic [35:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    // verdict
    task automatic close_out;
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    // hub sources one word, master must see both halves
    task automatic hub_send(logic [35:0] w);
        @(negedge clk_sys);
        tx_valid = 1;
        tx_word = w;
        @(negedge clk_sys);
        tx_valid = 0;
        check("tx ready after take", 36'(tx_ready), 36'h0_0000_0000);
        do @(negedge link_clk); while (m_rv !== 1'b1);
        check("master word", m_rw, w);
        do @(negedge clk_sys); while (tx_ready !== 1'b1);
        check("hub own beat", 36'(h_v), 36'h0_0000_0000);
    endtask : hub_send
    // pop one hub data word
    task automatic hub_take(logic [35:0] w);
        do @(negedge clk_sys); while (h_v !== 1'b1);
        check("hub word", h_w, w);
        h_rdy = 1;
        @(negedge clk_sys);
        h_rdy = 0;
    endtask : hub_take
    // master sends two words back to back with a sideband byte alongside
    task automatic mst_send(logic [35:0] a, logic [35:0] b, logic [7:0] s);
        @(negedge link_clk);
        m_tv = 1;
        m_tw = a;
        m_sv = 1;
        m_sa = s;
        @(negedge link_clk);
        m_sv = 0;
        m_tw = b;
        @(negedge link_clk);
        m_tv = 0;
        hub_take(a);
        hub_take(b);
        do @(negedge clk_sys); while (s_v !== 1'b1);
        check("hub sideband", 36'(s_a), 36'(s));
        s_rdy = 1;
        @(negedge clk_sys);
        s_rdy = 0;
    endtask : mst_send
    // main sequence, double rate then quad rate
    initial begin
        repeat (6) @(negedge clk_sys);
        reset_n = 1;
        for (int m = 0; m < 2; m++) begin
            repeat (4) @(negedge link_clk);
            quad = m[0];
            repeat (8) @(negedge link_clk);
            hub_send(36'hA_1234_5678 ^ 36'(m));
            mst_send(36'h5_C3A5_0F96 + 36'(m), 36'h6_EDCB_A987, 8'h3C + 8'(m));
        end
        close_out();
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            close_out();
        end
    end
endmodule : graphics_port_strobe_timing_tb_top
